// ===== src/snpr_pkg.sv
// Shared constants and types for the serial-number, power-down and
// soft-reset command block.
// Assumes a single-lane serial link in mode 0 and a 10 MHz core clock.
package snpr_pkg;

    // ********************************************************
    // Command codes
    // ********************************************************
    localparam logic [7:0] OP_SERIAL_WRITE = 8'hC2;
    localparam logic [7:0] OP_SERIAL_READ = 8'hC3;
    localparam logic [7:0] OP_WRITE_ARM = 8'h06;
    localparam logic [7:0] OP_DEEP_POWERDOWN = 8'hB9;
    localparam logic [7:0] OP_HIBERNATE = 8'hBA;
    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET_FIRE = 8'h99;

    // ********************************************************
    // Frame layout and reset values
    // ********************************************************
    localparam logic [7:0] OPCODE_BITS = 8'h08;
    localparam logic [7:0] SN_FRAME_BITS = 8'h48;
    localparam logic [7:0] SN_BITS = 8'h40;
    localparam logic [63:0] SN_RESET = 64'h0000_0000_0000_0000;

    // Dummy cycles selected by the two latency code bits.
    localparam logic [7:0] DUMMY_LC0 = 8'h00;
    localparam logic [7:0] DUMMY_LC1 = 8'h02;
    localparam logic [7:0] DUMMY_LC2 = 8'h04;
    localparam logic [7:0] DUMMY_LC3 = 8'h08;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_WAKE_PULSE_NS = 3000;
    localparam int T_PD_EXIT_NS = 10000;
    localparam int T_HIB_EXIT_NS = 450000;
    localparam int T_SOFT_RESET_NS = 50000;
    // Least time rounds up, longest times round down.
    localparam int WAKE_PULSE_CYC =
        (T_WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PD_EXIT_CYC = T_PD_EXIT_NS / CLK_PERIOD_NS;
    localparam int HIB_EXIT_CYC = T_HIB_EXIT_NS / CLK_PERIOD_NS;
    localparam int SOFT_RESET_CYC = T_SOFT_RESET_NS / CLK_PERIOD_NS;

    // ********************************************************
    // Types
    // ********************************************************
    typedef enum logic [2:0] {
        ST_READY = 3'b000,
        ST_PD = 3'b001,
        ST_PD_WAKE = 3'b010,
        ST_HIB = 3'b011,
        ST_HIB_WAKE = 3'b100,
        ST_SRST = 3'b101
    } snpr_state_t;

    // One finished frame as seen by the core clock.
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] bits;
    } snpr_frame_t;

endpackage

// ===== src/snpr_core.sv
// Command handling for serial-number write/read, deep power-down,
// hibernate and two-step soft reset.
// Assumes a mode 0 single-lane host; sck only toggles while cs_n is low,
// and cs_n stays high at least 400 ns between frames.
`timescale 1ns/1ps

module snpr_core
    import snpr_pkg::*;
#(
    parameter int WAKE_PULSE = WAKE_PULSE_CYC,
    parameter int PD_EXIT = PD_EXIT_CYC,
    parameter int HIB_EXIT = HIB_EXIT_CYC,
    parameter int SOFT_RESET = SOFT_RESET_CYC
)
(
    input wire logic clock, // Core clock, 10 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic sck, // Link serial clock.
    input wire logic cs_n, // Chip select pin, active low.
    input wire logic mosi, // Serial data into the device.
    output logic miso, // Serial data out of the device.
    output logic miso_oe, // High while the device drives miso.
    input wire logic [1:0] latency_code, // Read latency bits.
    output logic write_enable_latch, // Write enable latch state.
    output logic [63:0] user_serial_number, // Stored serial number.
    output logic powered_down, // Deep power-down or its wakeup.
    output logic hibernating, // Hibernate or its wakeup.
    output logic status_read_only, // Soft reset in progress.
    output logic integrity_clear, // Pulse: clear checksum/error regs.
    output logic defaults_reload // Pulse: reload power-on defaults.
);

    // ********************************************************
    // Frame counter on the rising edge of chip select
    // ********************************************************
    logic [1:0] fid_r;
    logic [1:0] fid_nxt;

    always_comb
    begin
        fid_nxt = fid_r + 2'b01;
    end

    always_ff @(posedge cs_n or posedge rst)
    begin
        if (rst)
            fid_r <= 2'b00;
        else
            fid_r <= fid_nxt;
    end

    // ********************************************************
    // Link domain: opcode and data shifting on rising sck
    // ********************************************************
    logic [7:0] bits_r;
    logic [7:0] bits_nxt;
    logic [7:0] op_r;
    logic [7:0] op_nxt;
    logic [63:0] data_r;
    logic [63:0] data_nxt;
    logic [1:0] seen_r;
    logic [1:0] seen_nxt;
    logic [7:0] base;

    // The first edge of a new frame is found by comparing frame ids, so
    // the counts of a finished frame stay put until the next one starts.
    always_comb
    begin
        base = (seen_r != fid_r) ? 8'h00 : bits_r;
        seen_nxt = fid_r;
        bits_nxt = (base == 8'hFF) ? base : base + 8'h01;
        op_nxt = op_r;
        data_nxt = data_r;
        if (base < OPCODE_BITS)
            op_nxt = {op_r[6:0], mosi};
        else if (base < SN_FRAME_BITS)
            data_nxt = {mosi, data_r[63:1]};
    end

    always_ff @(posedge sck or posedge rst)
    begin
        if (rst)
        begin
            bits_r <= 8'h00;
            op_r <= 8'h00;
            data_r <= 64'h0;
            seen_r <= 2'b00;
        end
        else
        begin
            bits_r <= bits_nxt;
            op_r <= op_nxt;
            data_r <= data_nxt;
            seen_r <= seen_nxt;
        end
    end

    // ********************************************************
    // Link domain: serial-number read data on falling sck
    // ********************************************************
    logic [63:0] sn_r;
    logic [1:0] lat_r;
    snpr_state_t st_r;
    logic rd_r;
    logic rd_nxt;
    logic so_r;
    logic so_nxt;
    logic [7:0] dummy;
    logic [7:0] idx;

    // sn_r only changes between frames and lat_r copies latency_code every clock, so both are stable here while latency_code is held.
    always_comb
    begin
        case (lat_r)
            2'b00: dummy = DUMMY_LC0;
            2'b01: dummy = DUMMY_LC1;
            2'b10: dummy = DUMMY_LC2;
            default: dummy = DUMMY_LC3;
        endcase
        idx = bits_r - OPCODE_BITS - dummy;
        rd_nxt = (seen_r == fid_r) && (op_r == OP_SERIAL_READ)
            && (bits_r >= OPCODE_BITS + dummy);
        so_nxt = 1'b0;
        if (rd_nxt && idx < SN_BITS)
            so_nxt = sn_r[idx[5:0]];
    end

    always_ff @(negedge sck or posedge rst)
    begin
        if (rst)
        begin
            rd_r <= 1'b0;
            so_r <= 1'b0;
        end
        else
        begin
            rd_r <= rd_nxt;
            so_r <= so_nxt;
        end
    end

    assign miso = so_r;
    // Only an awake, idle-state device drives the pin.
    assign miso_oe = rd_r && !cs_n && (st_r == ST_READY);

    // ********************************************************
    // Core domain: chip select synchroniser
    // ********************************************************
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_d_r;
    logic [2:0] cs_nxt;

    always_comb
    begin
        cs_nxt = {cs_n, cs_s1_r, cs_s2_r};
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_d_r <= 1'b1;
        end
        else
        begin
            cs_s1_r <= cs_nxt[2];
            cs_s2_r <= cs_nxt[1];
            cs_d_r <= cs_nxt[0];
        end
    end

    // ********************************************************
    // Core domain: command state machine
    // ********************************************************
    snpr_state_t st_nxt;
    logic [23:0] tmr_r;
    logic [23:0] tmr_nxt;
    logic wel_r;
    logic wel_nxt;
    logic arm_r;
    logic arm_nxt;
    logic [63:0] sn_nxt;
    logic [1:0] lat_nxt;
    logic clr_r;
    logic clr_nxt;
    logic rld_r;
    logic rld_nxt;
    logic cs_rise;
    logic cs_fall;
    logic frame_ok;
    snpr_frame_t fr;

    always_comb
    begin
        cs_rise = cs_s2_r && !cs_d_r;
        cs_fall = !cs_s2_r && cs_d_r;
        // A frame with no sck edge leaves seen_r two ids behind.
        frame_ok = cs_rise && (seen_r == fid_r - 2'b01);
        fr.opcode = op_r;
        fr.bits = bits_r;
        st_nxt = st_r;
        tmr_nxt = tmr_r;
        wel_nxt = wel_r;
        arm_nxt = arm_r;
        sn_nxt = sn_r;
        lat_nxt = latency_code;
        clr_nxt = 1'b0;
        rld_nxt = 1'b0;
        case (st_r)
            ST_READY:
            begin
                if (frame_ok)
                begin
                    arm_nxt = 1'b0;
                    if (fr.bits == OPCODE_BITS)
                    begin
                        case (fr.opcode)
                            OP_WRITE_ARM: wel_nxt = 1'b1;
                            OP_RESET_ARM: arm_nxt = 1'b1;
                            OP_RESET_FIRE:
                            begin
                                if (arm_r)
                                begin
                                    st_nxt = ST_SRST;
                                    tmr_nxt = 24'(SOFT_RESET);
                                    wel_nxt = 1'b0;
                                    clr_nxt = 1'b1;
                                end
                            end
                            OP_DEEP_POWERDOWN:
                            begin
                                st_nxt = ST_PD;
                                tmr_nxt = 24'h0;
                                wel_nxt = 1'b0;
                                clr_nxt = 1'b1;
                            end
                            OP_HIBERNATE:
                            begin
                                st_nxt = ST_HIB;
                                wel_nxt = 1'b0;
                            end
                            default: ;
                        endcase
                    end
                    if (fr.opcode == OP_SERIAL_WRITE)
                    begin
                        wel_nxt = 1'b0;
                        if (wel_r && fr.bits == SN_FRAME_BITS)
                            sn_nxt = data_r;
                    end
                end
            end
            ST_PD:
            begin
                // Count how long cs_n has been low; sck is ignored here.
                if (cs_s2_r)
                    tmr_nxt = 24'h0;
                else if (tmr_r >= 24'(WAKE_PULSE - 1))
                begin
                    st_nxt = ST_PD_WAKE;
                    tmr_nxt = 24'(PD_EXIT);
                end
                else
                    tmr_nxt = tmr_r + 24'h1;
            end
            ST_HIB:
            begin
                if (cs_fall)
                begin
                    st_nxt = ST_HIB_WAKE;
                    tmr_nxt = 24'(HIB_EXIT);
                end
            end
            ST_PD_WAKE, ST_SRST:
            begin
                // Frames ending here are dropped
                if (tmr_r <= 24'h1)
                    st_nxt = ST_READY;
                tmr_nxt = (tmr_r == 24'h0) ? 24'h0 : tmr_r - 24'h1;
            end
            ST_HIB_WAKE:
            begin
                if (tmr_r <= 24'h1)
                begin
                    st_nxt = ST_READY;
                    wel_nxt = 1'b0;
                    arm_nxt = 1'b0;
                    rld_nxt = 1'b1;
                    clr_nxt = 1'b1;
                end
                tmr_nxt = (tmr_r == 24'h0) ? 24'h0 : tmr_r - 24'h1;
            end
            default:
            begin
                st_nxt = ST_READY;
                tmr_nxt = 24'h0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_r <= ST_READY;
            tmr_r <= 24'h0;
            wel_r <= 1'b0;
            arm_r <= 1'b0;
            sn_r <= SN_RESET;
            lat_r <= 2'b00;
            clr_r <= 1'b0;
            rld_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            wel_r <= wel_nxt;
            arm_r <= arm_nxt;
            sn_r <= sn_nxt;
            lat_r <= lat_nxt;
            clr_r <= clr_nxt;
            rld_r <= rld_nxt;
        end
    end

    assign write_enable_latch = wel_r;
    assign user_serial_number = sn_r;
    assign powered_down = (st_r == ST_PD) || (st_r == ST_PD_WAKE);
    assign hibernating = (st_r == ST_HIB) || (st_r == ST_HIB_WAKE);
    assign status_read_only = (st_r == ST_SRST);
    assign integrity_clear = clr_r;
    assign defaults_reload = rld_r;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence cmd_end_s(logic [7:0] op);
        st_r == ST_READY && frame_ok && fr.opcode == op
            && fr.bits == OPCODE_BITS;
    endsequence

    sequence hib_wake_s;
        st_r == ST_HIB && cs_fall ##1 st_r == ST_HIB_WAKE;
    endsequence

    wel_clear_a: assert property (
        st_r == ST_READY && frame_ok && fr.opcode == OP_SERIAL_WRITE
        |=> !wel_r)
        else $error("latch not cleared after serial write");

    sn_gate_a: assert property (
        sn_r != $past(sn_r) |-> $past(wel_r)
            && $past(fr.bits) == SN_FRAME_BITS)
        else $error("serial number changed without enable or 8 bytes");

    pd_entry_a: assert property (
        cmd_end_s(OP_DEEP_POWERDOWN) |=> st_r == ST_PD && clr_r)
        else $error("power-down entry missed");

    pd_latch_a: assert property (
        powered_down |-> !wel_r)
        else $error("latch kept in power-down");

    quiet_out_a: assert property (
        st_r != ST_READY |-> !miso_oe)
        else $error("output driven while asleep or resetting");

    hib_entry_a: assert property (
        cmd_end_s(OP_HIBERNATE) |=> st_r == ST_HIB)
        else $error("hibernate entry missed");

    hib_exit_a: assert property (
        hib_wake_s |-> ##[1:HIB_EXIT] (st_r == ST_READY && rld_r))
        else $error("hibernate wakeup not bounded");

    arm_cancel_a: assert property (
        st_r == ST_READY && frame_ok && fr.opcode != OP_RESET_ARM
        |=> !arm_r)
        else $error("reset arm not cancelled");

    srst_start_a: assert property (
        cmd_end_s(OP_RESET_FIRE) and arm_r |=> st_r == ST_SRST)
        else $error("soft reset not started");

    srst_hold_a: assert property (
        $rose(st_r == ST_SRST) |-> st_r == ST_SRST [*8])
        else $error("soft reset left too early");

endmodule

// ===== tb/snpr_host.sv
// SPI host model that frames commands for the command block.
// Assumes mode 0 and a link clock that runs only inside frames.
`timescale 1ns/1ps

module snpr_host
(
    output logic sck, // Link clock, idle low.
    output logic cs_n, // Chip select, active low.
    output logic mosi, // Data to the device.
    input wire logic miso, // Data from the device.
    input wire logic miso_oe // High while the device drives miso.
);
    localparam realtime HALF = 62.5;

    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // A released data line reads as unknown so a stale bit never matches.
    task automatic bit_cyc(input logic b, output logic s);
        mosi = b;
        #HALF;
        sck = 1'b1;
        s = miso_oe ? miso : 1'bx;
        #HALF;
        sck = 1'b0;
    endtask

    task automatic frame(input logic [7:0] op, input logic [63:0] wd,
        input int nw, input int nd, input int nr, output logic [63:0] rd);
        logic s;
        rd = 64'h0;
        cs_n = 1'b0;
        #HALF;
        for (int i = 0; i < 8; i++)
        begin
            bit_cyc(op[7 - i], s);
        end
        for (int i = 0; i < nw; i++)
        begin
            bit_cyc(wd[i % 64], s);
        end
        for (int i = 0; i < nd + nr; i++)
        begin
            bit_cyc(~mosi, s);
            if (i >= nd && i - nd < 64)
            begin
                rd[i - nd] = s;
            end
        end
        #HALF;
        cs_n = 1'b1;
        mosi = ~mosi;
        #600;
    endtask

    // Chip select alone; the link clock stays still.
    task automatic pulse(input realtime len);
        cs_n = 1'b0;
        #len;
        cs_n = 1'b1;
        #600;
    endtask
endmodule

// ===== tb/test_snpr_core.sv
// Self-checking bench for the command block, driven by an SPI host model.
// Assumes shortened hibernate exit and soft reset counts set at the instance.
`timescale 1ns/1ps

module test_snpr_core
    import snpr_pkg::*;
;
    localparam int SRST = 40;
    typedef struct packed {logic [1:0] lc; logic [55:0] id;} snpr_row_t;
    logic clock, rst, sck, cs_n, mosi, miso, miso_oe;
    logic [1:0] latency_code;
    logic write_enable_latch, powered_down, hibernating;
    logic status_read_only, integrity_clear, defaults_reload;
    logic [63:0] user_serial_number, rd, sn_exp;
    logic oe_seen = 1'b0;
    int err_count = 0;
    int n_tests = 0;
    int ic_count = 0;
    int dr_count = 0;
    int n, m;
    snpr_row_t rows [4] = '{'{2'h0, 56'h12_3456_789A_BCDE},
        '{2'h1, 56'hFF_0000_FFFF_0001}, '{2'h2, 56'h80_4020_1008_0402},
        '{2'h3, 56'hA5_5AA5_5AA5_5AC3}};

    // Wake pulse and power-down exit keep their real lengths.
    snpr_core #(.HIB_EXIT(20),
        .SOFT_RESET(SRST)) u_dut (.clock(clock), .rst(rst), .sck(sck),
        .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .latency_code(latency_code),
        .write_enable_latch(write_enable_latch),
        .user_serial_number(user_serial_number),
        .powered_down(powered_down), .hibernating(hibernating),
        .status_read_only(status_read_only),
        .integrity_clear(integrity_clear),
        .defaults_reload(defaults_reload));

    snpr_host u_host (.sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe(miso_oe));

    // ********************************************************
    // Helpers
    // ********************************************************
    always @(posedge clock)
    begin
        if (integrity_clear === 1'b1)
        begin
            ic_count <= ic_count + 1;
        end
        if (defaults_reload === 1'b1)
        begin
            dr_count <= dr_count + 1;
        end
        if (miso_oe === 1'b1)
        begin
            oe_seen <= 1'b1;
        end
    end

    // The host appends its own check byte; the block computes none.
    function automatic logic [63:0] mk_sn(input logic [55:0] id);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 7; i++)
        begin
            c = c ^ id[i * 8 +: 8];
        end
        return {id, c};
    endfunction

    function automatic int dummy_of(input logic [1:0] lc);
        case (lc)
            2'h0: return DUMMY_LC0;
            2'h1: return DUMMY_LC1;
            2'h2: return DUMMY_LC2;
            default: return DUMMY_LC3;
        endcase
    endfunction

    task automatic check(input string name, input logic [63:0] seen,
        input logic [63:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ********************************************************
    // Stimulus
    // ********************************************************
    initial
    begin
        clock = 1'b0;
        forever
        begin
            #50 clock = ~clock;
        end
    end

    initial
    begin
        #2000000;
        err_count++;
        print_verdict();
    end

    initial
    begin
        rst = 1'b1;
        latency_code = 2'h0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        repeat (3) @(negedge clock);
        check("serial number", user_serial_number, SN_RESET);
        check("latch", write_enable_latch, 1'b0);
        check("flags", {powered_down, hibernating, status_read_only}, 3'h0);
        foreach (rows[k])
        begin
            @(negedge clock) latency_code = rows[k].lc;
            sn_exp = mk_sn(rows[k].id);
            u_host.frame(OP_WRITE_ARM, 64'h0, 0, 0, 0, rd);
            check("latch set", write_enable_latch, 1'b1);
            u_host.frame(OP_SERIAL_WRITE, sn_exp, 64, 0, 0, rd);
            check("written", user_serial_number, sn_exp);
            check("latch cleared", write_enable_latch, 1'b0);
            u_host.frame(OP_SERIAL_READ, 64'h0, 0, dummy_of(rows[k].lc),
                64, rd);
            check("read data", rd, sn_exp);
        end
        u_host.frame(OP_SERIAL_WRITE, ~sn_exp, 64, 0, 0, rd);
        check("unarmed write", user_serial_number, sn_exp);
        u_host.frame(OP_WRITE_ARM, 64'h0, 0, 0, 0, rd);
        u_host.frame(OP_SERIAL_WRITE, ~sn_exp, 56, 0, 0, rd);
        check("short write", user_serial_number, sn_exp);
        check("latch short", write_enable_latch, 1'b0);
        u_host.frame(OP_WRITE_ARM, 64'h0, 0, 0, 0, rd);
        u_host.frame(OP_SERIAL_WRITE, ~sn_exp, 72, 0, 0, rd);
        check("long write", user_serial_number, sn_exp);
        u_host.frame(OP_WRITE_ARM, 64'h0, 0, 0, 0, rd);
        n = ic_count;
        u_host.frame(OP_DEEP_POWERDOWN, 64'h0, 0, 0, 0, rd);
        check("powered down", powered_down, 1'b1);
        check("clear pulse", ic_count - n, 1);
        oe_seen = 1'b0;
        u_host.pulse(200);
        check("short wake", powered_down, 1'b1);
        u_host.pulse(3600);
        check("waking", powered_down, 1'b1);
        #11000;
        check("awake", powered_down, 1'b0);
        check("quiet output", oe_seen, 1'b0);
        check("latch after pd", write_enable_latch, 1'b0);
        u_host.frame(OP_WRITE_ARM, 64'h0, 0, 0, 0, rd);
        u_host.frame(OP_HIBERNATE, 64'h0, 0, 0, 0, rd);
        check("hibernating", hibernating, 1'b1);
        n = ic_count;
        m = dr_count;
        u_host.pulse(300);
        check("hib waking", hibernating, 1'b1);
        #3000;
        check("hib exit", hibernating, 1'b0);
        check("reload pulse", dr_count - m, 1);
        check("clear on exit", ic_count - n, 1);
        check("latch reload", write_enable_latch, 1'b0);
        check("serial kept", user_serial_number, sn_exp);
        u_host.frame(OP_RESET_ARM, 64'h0, 0, 0, 0, rd);
        u_host.frame(OP_WRITE_ARM, 64'h0, 0, 0, 0, rd);
        u_host.frame(OP_RESET_FIRE, 64'h0, 0, 0, 0, rd);
        check("cancelled reset", status_read_only, 1'b0);
        u_host.frame(OP_RESET_ARM, 64'h0, 0, 0, 0, rd);
        u_host.frame(OP_RESET_FIRE, 64'h0, 0, 0, 0, rd);
        check("soft reset", status_read_only, 1'b1);
        oe_seen = 1'b0;
        u_host.frame(OP_SERIAL_READ, 64'h0, 0, 0, 8, rd);
        check("read refused", oe_seen, 1'b0);
        #4000;
        check("reset done", status_read_only, 1'b0);
        @(negedge clock) rst = 1'b1;
        @(negedge clock) rst = 1'b0;
        check("serial after rst", user_serial_number, SN_RESET);
        print_verdict();
    end
endmodule
